// [hw/wdg_guard.v]
// Purpose: watchdog with write-once mode and keyed service register, APB slave
// Assumes: low-speed tick derived from pclk by a divider; option byte as a pin
// Notes:   internal reset is a pulse on wdg_reset_req; the system resets us in turn
// Behaviour
// - Only the first mode write after reset is accepted; later ones reset.
// - Stopped-by-first-write watchdog suppresses resets from misuse accesses.
// - Service key write other than AC raises an internal reset.
// - Bit-level access to the service key raises an internal reset.
// - Service key reads back fixed 9A.
// - Unstoppable oscillator keeps counting in stop and resets on overflow.
// - Stoppable oscillator pauses in halt or stop and resumes held count.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "wdg_defines.vh"
module wdg_guard (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Option byte and power state
  input  wire        osc_unstoppable,
  input  wire        cpu_halt,
  input  wire        cpu_stop,
  // Results
  output reg         wdg_reset_req,
  output wire        irq
);
  // Counting phases of the watchdog
  localparam PH_IDLE = 2'b00;
  localparam PH_RUN  = 2'b01;
  localparam PH_HOLD = 2'b10;
  localparam PH_OFF  = 2'b11;

  // Write-once mode register and the flags it leaves behind
  reg  [7:0]               mode_reg;
  reg                      mode_written_reg;
  reg                      stopped_reg;

  // Software controls and event bookkeeping
  reg  [2:0]               ctrl_reg;
  reg  [3:0]               mask_reg;
  reg  [3:0]               status_reg;
  reg  [3:0]               status_next;

  // Counter, prescaler and phase
  reg  [`WDG_CNT_W-1:0]    count_reg;
  reg  [`WDG_CNT_W-1:0]    count_next;
  reg  [`WDG_PRE_W-1:0]    pre_reg;
  reg  [`WDG_PRE_W-1:0]    pre_next;
  reg  [1:0]               phase_reg;
  reg  [1:0]               phase_next;

  // Internal reset stretcher
  reg  [3:0]               pulse_reg;
  reg  [3:0]               pulse_next;

  // Option byte synchroniser
  reg  [2:0]               osc_sync_reg;
  reg                      osc_level_reg;

  // Event vector and read data
  reg  [3:0]               ev;
  reg                      fault;
  reg  [31:0]              rd_word;

  // Address decode shared by the write strobes
  function sel_is;
    input [11:0] a;
    input [11:0] off;
    begin
      sel_is = (a == off);
    end
  endfunction

  // Overflow limit from the clock-select field kept active when running
  function [`WDG_CNT_W-1:0] limit_of;
    input [7:0] m;
    begin
      case (m[`WDG_MODE_CS_LO:`WDG_MODE_CS_MID-1])
        3'b000:  limit_of = `WDG_LIM_0;
        3'b001:  limit_of = `WDG_LIM_1;
        3'b010:  limit_of = `WDG_LIM_2;
        3'b011:  limit_of = `WDG_LIM_3;
        default: limit_of = `WDG_LIM_MAX;
      endcase
    end
  endfunction

  // Register read mux; unused upper bits read as zero
  function [31:0] read_mux;
    input [11:0] a;
    input [7:0]  mode;
    input [2:0]  ctrl;
    input [3:0]  status;
    input [3:0]  mask;
    input [21:0] cnt;
    begin
      case (a)
        `WDG_OFF_MODE:   read_mux = {24'h000000, mode};
        `WDG_OFF_KEY:    read_mux = {24'h000000, `WDG_KEY_READ};
        `WDG_OFF_CTRL:   read_mux = {29'h0000000, ctrl};
        `WDG_OFF_STATUS: read_mux = {28'h0000000, status};
        `WDG_OFF_MASK:   read_mux = {28'h0000000, mask};
        `WDG_OFF_COUNT:  read_mux = {10'h000, cnt};
        default:         read_mux = 32'h00000000;
      endcase
    end
  endfunction

  // APB decode; pready is tied high, so the access cycle is the taking edge
  wire acc       = psel & penable;
  wire wr        = acc & pwrite;
  wire rd        = acc & ~pwrite;
  wire rd_setup  = psel & ~penable & ~pwrite;
  wire wr_mode   = wr & sel_is(paddr, `WDG_OFF_MODE);
  wire wr_key    = wr & sel_is(paddr, `WDG_OFF_KEY);
  wire wr_bit    = wr & sel_is(paddr, `WDG_OFF_BITOP);
  wire wr_ctrl   = wr & sel_is(paddr, `WDG_OFF_CTRL);
  wire wr_mask   = wr & sel_is(paddr, `WDG_OFF_MASK);
  wire rd_status = rd & sel_is(paddr, `WDG_OFF_STATUS);
  wire mapped    = (paddr[11:5] == 7'h00) && (paddr[4:0] <= 5'h18) && (paddr[1:0] == 2'b00);
  wire key_ok    = (pwdata[7:0] == `WDG_KEY_GOOD);

  // Prescaler end marks one slow tick
  wire tick      = (pre_reg == `WDG_PRE_DIV);

  // A stopped watchdog ignores misuse, so faults only count while not stopped
  wire guard     = ~stopped_reg;
  wire sleep     = ctrl_reg[`WDG_CTRL_HALT] | ctrl_reg[`WDG_CTRL_STOP] | cpu_halt | cpu_stop;
  wire unstop    = osc_level_reg | ctrl_reg[`WDG_CTRL_UNSTOP];
  wire ovf       = (phase_reg == PH_RUN) && tick && (count_reg == limit_of(mode_reg));
  wire [21:0] cnt_word = {stopped_reg, mode_written_reg, count_reg};

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign irq     = |(status_reg & mask_reg);

  // Option byte comes from outside the clock domain.
  // The level is taken only once the last two stages agree, so a glitch caught at a single clock edge never counts.
  // Limitation: the level after reset lags the pin by a few cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_reg  <= 3'b000;
      osc_level_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], osc_unstoppable};
      if (osc_sync_reg[1] == osc_sync_reg[2]) begin
        osc_level_reg <= osc_sync_reg[2];
      end
    end
  end

  // Misuse events; overflow shares the vector so it also drives the reset pulse
  always @* begin
    ev = 4'h0;
    ev[`WDG_ST_OVF]    = ovf;
    ev[`WDG_ST_MODE2]  = wr_mode & mode_written_reg & guard;
    ev[`WDG_ST_BADKEY] = wr_key & ~key_ok & guard;
    ev[`WDG_ST_BITOP]  = wr_bit & guard;
    fault = |ev;
  end

  // Phase of the counter
  always @* begin
    case (phase_reg)
      PH_IDLE: phase_next = stopped_reg ? PH_OFF : PH_RUN;
      PH_RUN:  phase_next = stopped_reg ? PH_OFF : ((sleep & ~unstop) ? PH_HOLD : PH_RUN);
      PH_HOLD: phase_next = (sleep & ~unstop) ? PH_HOLD : PH_RUN;
      PH_OFF:  phase_next = PH_OFF;
      default: phase_next = PH_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Mode is taken once; the flag keeps later writes out until a device reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg         <= `WDG_MODE_RESET;
      mode_written_reg <= 1'b0;
      stopped_reg      <= 1'b0;
    end else if (wr_mode && !mode_written_reg) begin
      mode_reg         <= pwdata[7:0];
      mode_written_reg <= 1'b1;
      stopped_reg      <= pwdata[`WDG_MODE_CS_HI];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 4'h0;
    end else if (wr_mask) begin
      mask_reg <= pwdata[3:0];
    end
  end

  // Count and prescaler; held, not cleared, while paused
  always @* begin
    pre_next   = pre_reg;
    count_next = count_reg;
    if (phase_reg == PH_RUN) begin
      if (tick) begin
        pre_next = {`WDG_PRE_W{1'b0}};
      end else begin
        pre_next = pre_reg + 4'h1;
      end
    end
    if (wr_key && key_ok) begin
      count_next = {`WDG_CNT_W{1'b0}};
    end else if (ovf) begin
      count_next = {`WDG_CNT_W{1'b0}};
    end else if (phase_reg == PH_RUN && tick) begin
      count_next = count_reg + 20'h00001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {`WDG_CNT_W{1'b0}};
      pre_reg   <= {`WDG_PRE_W{1'b0}};
    end else begin
      count_reg <= count_next;
      pre_reg   <= pre_next;
    end
  end

  // Sticky status, cleared by a read; a new event in the same cycle wins
  always @* begin
    if (rd_status) begin
      status_next = ev;
    end else begin
      status_next = status_reg | ev;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Internal reset pulse stretched so the system reset logic can catch it.
  // A fault during the pulse restarts it rather than being lost.
  always @* begin
    if (fault) begin
      pulse_next = `WDG_RST_PULSE;
    end else if (pulse_reg != 4'h0) begin
      pulse_next = pulse_reg - 4'h1;
    end else begin
      pulse_next = pulse_reg;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg     <= 4'h0;
      wdg_reset_req <= 1'b0;
    end else begin
      pulse_reg     <= pulse_next;
      wdg_reset_req <= fault | (pulse_reg > 4'h1);
    end
  end

  // Read data is captured in the setup cycle so it stands through the access
  always @* begin
    rd_word = read_mux(paddr, mode_reg, ctrl_reg, status_reg, mask_reg, cnt_word);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end
endmodule // wdg_guard

// [hw/wdg_defines.vh]
// Purpose: constants for the guarded watchdog block
// Assumes: APB byte addresses, 100 MHz pclk
// Notes:   one aligned 32-bit word per register, data in the low bits (at most 8, but 22 for the count word)
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH
`define WDG_OFF_MODE        12'h000
`define WDG_OFF_KEY         12'h004
`define WDG_OFF_BITOP       12'h008
`define WDG_OFF_CTRL        12'h00c
`define WDG_OFF_STATUS      12'h010
`define WDG_OFF_MASK        12'h014
`define WDG_OFF_COUNT       12'h018
`define WDG_KEY_GOOD        8'hac
`define WDG_KEY_READ        8'h9a
`define WDG_MODE_RESET      8'h67
`define WDG_MODE_CS_HI      4
`define WDG_MODE_CS_LO      3
`define WDG_MODE_CS_MID     2
`define WDG_CTRL_UNSTOP     0
`define WDG_CTRL_HALT       1
`define WDG_CTRL_STOP       2
`define WDG_ST_OVF          0
`define WDG_ST_MODE2        1
`define WDG_ST_BADKEY       2
`define WDG_ST_BITOP        3
`define WDG_LIM_0           20'h003ff
`define WDG_LIM_1           20'h00fff
`define WDG_LIM_2           20'h03fff
`define WDG_LIM_3           20'h0ffff
`define WDG_LIM_MAX         20'hfffff
`define WDG_CNT_W           20
`define WDG_PRE_W           4
`define WDG_PRE_DIV         4'h9
`define WDG_RST_PULSE       4'h8
`endif

// [verification/wdg_master.sv]
// Purpose: APB core model that drives wdg_guard
// Assumes: one transfer at a time, byte data in bits 7:0
// Notes:   an idle cycle precedes each setup
`timescale 1ns/1ps
module wdg_master (
  // APB
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  // Wait overrun
  output reg         to
);
  initial {psel, penable, pwrite, paddr, pwdata, to} = 0;
  task xf(input w, input [11:0] a, input [7:0] d, output [31:0] r);
    integer n;
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge pclk);
      end
      to <= to | (n == 16);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep showing the old value
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
    end
  endtask
endmodule // wdg_master

// [verification/wdg_guard_asserts.sv]
// Purpose: port checks for wdg_guard
// Assumes: faults pulse wdg_reset_req from the edge after the write
// Notes:   stop state is rebuilt from the first mode write seen
`timescale 1ns/1ps
module wdg_guard_asserts (
  // Watched ports
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        wdg_reset_req
);
  reg  mw_reg;
  reg  st_reg;
  wire wr = psel & penable & pwrite;
  wire fm = wr & (paddr == 12'h000);
  wire fk = wr & (paddr == 12'h004);
  wire fb = wr & (paddr == 12'h008);
  wire rk = psel & penable & !pwrite & (paddr == 12'h004);
  always @(posedge pclk or negedge presetn)
    if (!presetn) {mw_reg, st_reg} <= 2'b00;
    else if (fm & !mw_reg) {mw_reg, st_reg} <= {1'b1, pwdata[4]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  key_read_a: assert property (rk |-> prdata == 32'h9a) else $error("key read");
  good_key_a: assert property (fk & pwdata[7:0] == 8'hac |=> !$rose(wdg_reset_req))
    else $error("good key reset");
  bad_key_a: assert property (fk & pwdata[7:0] != 8'hac & !st_reg |=> wdg_reset_req)
    else $error("bad key no reset");
  bit_op_a: assert property (fb & !st_reg |=> wdg_reset_req) else $error("bit op");
  mode_twice_a: assert property (fm & mw_reg & !st_reg |=> wdg_reset_req)
    else $error("second mode write");
  mode_first_a: assert property (fm & !mw_reg |=> !$rose(wdg_reset_req))
    else $error("first mode write");
  stop_quiet_a: assert property (st_reg & wr |=> !$rose(wdg_reset_req))
    else $error("reset while stopped");
  pulse_len_a: assert property ($rose(wdg_reset_req) |-> wdg_reset_req[*8])
    else $error("pulse short");
  cover property (fb & !st_reg);
  cover property (fm & mw_reg & st_reg);
  cover property (rk);
endmodule // wdg_guard_asserts
bind wdg_guard wdg_guard_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .wdg_reset_req(wdg_reset_req));

// [verification/testbench.sv]
// Purpose: self-checking bench for wdg_guard
// Assumes: zero-wait APB slave
// Notes:   overflow uses the shortest limit to keep the run short
`timescale 1ns/1ps
`include "wdg_defines.vh"
module testbench;
  reg         pclk, presetn, osc_unstoppable, cpu_halt, cpu_stop, se;
  wire        psel, penable, pwrite, pready, pslverr, wdg_reset_req, irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  reg  [31:0] r, h;
  integer     fails, num_checks;
  wdg_master m (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .to(),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  wdg_guard dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_unstoppable(osc_unstoppable), .cpu_halt(cpu_halt),
    .cpu_stop(cpu_stop), .wdg_reset_req(wdg_reset_req), .irq(irq));
  always @(posedge pclk) if (psel & penable) se <= pslverr;
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rd(input [11:0] a); m.xf(1'b0, a, 8'h00, r); endtask
  task fw(input [11:0] a, input [7:0] d, input e);
    begin
      m.xf(1'b1, a, d, r);
      #1 chk("reset_req", wdg_reset_req, e);
      repeat (9) @(posedge pclk);
    end
  endtask
  task rst;
    begin
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      fw(`WDG_OFF_MODE, 8'h67, 1'b0);
    end
  endtask
  task t_faults;
    begin
      m.xf(1'b1, `WDG_OFF_MASK, 8'h0e, r);
      #1 chk("ready", pready, 1'b1);
      fw(`WDG_OFF_KEY, 8'h5a, 1'b1);
      fw(`WDG_OFF_BITOP, 8'hac, 1'b1);
      fw(`WDG_OFF_MODE, 8'h63, 1'b1);
      rd(`WDG_OFF_MODE);
      #1 chk("mode_kept", r, 32'h67);
      chk("irq_set", irq, 1'b1);
      rd(`WDG_OFF_STATUS);
      chk("status", r[3:1], 3'h7);
      #1 chk("irq_clr", irq, 1'b0);
      rd(12'h020);
      #1 chk("unmapped", se, 1'b1);
      $display("t_faults done");
    end
  endtask
  task t_pause;
    begin
      cpu_halt <= 1'b1;
      rd(`WDG_OFF_COUNT);
      h = r;
      repeat (40) @(posedge pclk);
      rd(`WDG_OFF_COUNT);
      chk("held", r[19:0], h[19:0]);
      cpu_halt <= 1'b0;
      repeat (40) @(posedge pclk);
      rd(`WDG_OFF_COUNT);
      chk("resumed", r[19:0] > h[19:0] + 20'h2, 1'b1);
      m.xf(1'b1, `WDG_OFF_CTRL, 8'h02, r);
      rd(`WDG_OFF_COUNT);
      h = r;
      repeat (40) @(posedge pclk);
      rd(`WDG_OFF_COUNT);
      chk("ctrl_held", r[19:0], h[19:0]);
      m.xf(1'b1, `WDG_OFF_CTRL, 8'h00, r);
      osc_unstoppable <= 1'b1;
      repeat (5) @(posedge pclk);
      cpu_stop <= 1'b1;
      rd(`WDG_OFF_COUNT);
      h = r;
      repeat (40) @(posedge pclk);
      rd(`WDG_OFF_COUNT);
      chk("stop_runs", r[19:0] > h[19:0] + 20'h2, 1'b1);
      cpu_stop <= 1'b0;
      rd(`WDG_OFF_KEY);
      chk("key_read", r, 32'h9a);
      fw(`WDG_OFF_KEY, 8'hac, 1'b0);
      rd(`WDG_OFF_COUNT);
      chk("cleared", r[19:2], 18'h0);
      $display("t_pause done");
    end
  endtask
  task t_ovf;
    integer n;
    begin
      osc_unstoppable <= 1'b0;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      fw(`WDG_OFF_MODE, 8'h61, 1'b0);
      m.xf(1'b1, `WDG_OFF_MASK, 8'h01, r);
      n = 0;
      while (wdg_reset_req !== 1'b1 && n < 11000) begin
        n = n + 1;
        @(posedge pclk);
        #1;
      end
      chk("ovf_time", n > 10000 && n < 11000, 1'b1);
      chk("ovf_irq", irq, 1'b1);
      rd(`WDG_OFF_COUNT);
      chk("ovf_clear", r[19:4], 16'h0);
      rd(`WDG_OFF_STATUS);
      chk("ovf_status", r[0], 1'b1);
      $display("t_ovf done");
    end
  endtask
  task t_stop;
    begin
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      fw(`WDG_OFF_MODE, 8'h77, 1'b0);
      fw(`WDG_OFF_MODE, 8'h67, 1'b0);
      fw(`WDG_OFF_KEY, 8'h11, 1'b0);
      fw(`WDG_OFF_BITOP, 8'h00, 1'b0);
      rd(`WDG_OFF_COUNT);
      chk("stopped", r[21:20], 2'h3);
      $display("t_stop done");
    end
  endtask
  task end_of_test;
    begin
      fails = fails + m.to;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, osc_unstoppable, cpu_halt, cpu_stop, se} = 0;
    fails = 0;
    num_checks = 0;
    rst;
    t_faults;
    rst;
    t_pause;
    t_stop;
    t_ovf;
    end_of_test;
  end
  initial begin
    #600000;
    fails = fails + 1;
    end_of_test;
  end
endmodule // testbench
